// >>> adcp_pkg.sv
// constants, field layouts and types of the converter host command port
// assumes a single 50 MHz oscillator clock drives every count of the block
package adcp_pkg;

    localparam int unsigned CLK_PERIOD_NS = 20;

    // ----------------------------------------
    // sequence counter
    // ----------------------------------------
    localparam int unsigned CNT_W         = 11;
    localparam logic [10:0] CONV_LAST_CNT = 11'h71b;   // 1819, cycle of 1820 counts
    localparam logic [10:0] IDLE_CNT      = 11'h000;
    localparam logic [10:0] FIRST_CNT     = 11'h001;
    localparam logic [10:0] START_CLR_CNT = 11'h005;
    localparam logic [10:0] INT_START_CNT = 11'h070;
    localparam logic [10:0] INT_LEN_60    = 11'h222;   // 546 counts
    localparam logic [10:0] INT_LEN_50    = 11'h28f;   // 655 counts

    // ----------------------------------------
    // command byte fields
    // ----------------------------------------
    localparam int unsigned CMD_START_BIT = 7;
    localparam int unsigned CMD_MODE_BIT  = 6;
    localparam int unsigned CMD_SLEEP_BIT = 5;
    localparam int unsigned CMD_ZERO_BIT  = 4;
    localparam int unsigned CMD_SEL_LO    = 2;
    localparam int unsigned CMD_SEL_HI    = 1;

    // ----------------------------------------
    // status byte fields
    // ----------------------------------------
    localparam int unsigned ST_CLASH_BIT = 7;
    localparam int unsigned ST_EOC_BIT   = 6;
    localparam int unsigned ST_INT_BIT   = 5;
    localparam int unsigned ST_SLEEP_BIT = 4;
    localparam logic [7:0]  RESET_BYTE   = 8'h00;

    // select code is {reg_select_high, reg_select_low}
    typedef enum logic [1:0] {
        SEL_RES_LO  = 2'b00,
        SEL_RES_HI  = 2'b01,
        SEL_STATUS  = 2'b10,
        SEL_INVALID = 2'b11
    } adcp_sel_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CONV  = 2'b01,
        ST_SLEEP = 2'b10
    } adcp_state_e;

    typedef struct packed {
        logic      start;
        logic      mode50;
        logic      sleep;
        logic      read_zero;
        adcp_sel_e sel;
    } adcp_cmd_s;

    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic [7:0] data;
    } adcp_pins_s;

    localparam adcp_cmd_s CMD_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, SEL_RES_LO};

endpackage

// >>> adcp_host_port.sv
// command register, result readout and conversion sequencing of the converter
// assumes host pins are asynchronous and results arrive on ref_clk from the analog core
`timescale 1ns/1ps

module adcp_host_port
    import adcp_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [7:0]  data_in,
    output logic      [7:0]  data_out,
    output logic             data_oe,
    input  wire logic [15:0] result_in,
    input  wire logic [2:0]  fraction_in,
    output logic             eoc,
    output logic             integrating,
    output logic             read_zero,
    output logic             sleep_active
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    adcp_pins_s pins_meta_r;
    adcp_pins_s pins_r;
    adcp_pins_s pins_prev_r;

    // sample the byte bus pins
    // strobes are seen two cycles late, so pulses under one cycle may vanish
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pins_meta_r <= '{1'b1, 1'b1, 1'b1, 8'h00};
            pins_r      <= '{1'b1, 1'b1, 1'b1, 8'h00};
            pins_prev_r <= '{1'b1, 1'b1, 1'b1, 8'h00};
        end else if (clk_en) begin
            pins_meta_r <= '{cs_n, rd_n, wr_n, data_in};
            pins_r      <= pins_meta_r;
            pins_prev_r <= pins_r;
        end
    end

    logic reading;
    logic wr_done;
    logic rd_done;

    assign reading = !pins_r.cs_n && !pins_r.rd_n;
    // write ends on the rising strobe; data is taken from the cycle before it
    assign wr_done = !pins_prev_r.cs_n && !pins_prev_r.wr_n && pins_r.wr_n;
    assign rd_done = !pins_prev_r.cs_n && !pins_prev_r.rd_n && pins_r.rd_n;

    // ----------------------------------------
    // command register
    // ----------------------------------------
    adcp_cmd_s   cmd_r;
    adcp_state_e state_r;
    logic [10:0] cnt_r;
    logic        wr_start;
    logic        start_clr;

    assign wr_start  = wr_done && pins_prev_r.data[CMD_START_BIT];
    // a start written during counts 1..4 is lost to this self clear
    assign start_clr = clk_en && state_r == ST_CONV && cnt_r == START_CLR_CNT;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_r <= CMD_RESET;
        end else if (clk_en) begin
            if (wr_done) begin
                cmd_r.mode50    <= pins_prev_r.data[CMD_MODE_BIT];
                cmd_r.sleep     <= pins_prev_r.data[CMD_SLEEP_BIT];
                cmd_r.read_zero <= pins_prev_r.data[CMD_ZERO_BIT];
                // select at D1 high, D2 low
                cmd_r.sel       <= adcp_sel_e'({pins_prev_r.data[CMD_SEL_HI],
                                                pins_prev_r.data[CMD_SEL_LO]});
            end
            // self clear, a new write wins
            if (wr_start) begin
                cmd_r.start <= 1'b1;
            end else if (start_clr) begin
                cmd_r.start <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // conversion sequencer
    // ----------------------------------------
    logic [10:0] int_end;

    assign int_end = INT_START_CNT + (cmd_r.mode50 ? INT_LEN_50 : INT_LEN_60);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            cnt_r   <= IDLE_CNT;
        end else if (clk_en) begin
            case (state_r)
                ST_IDLE: begin
                    // a late start waits for this zero
                    if (cmd_r.start) begin
                        state_r <= ST_CONV;
                        cnt_r   <= FIRST_CNT;
                    end else if (cmd_r.sleep) begin
                        state_r <= ST_SLEEP;
                    end
                end
                ST_CONV: begin
                    // run to the end, then idle
                    if (cnt_r == CONV_LAST_CNT) begin
                        state_r <= ST_IDLE;
                        cnt_r   <= IDLE_CNT;
                    end else begin
                        cnt_r <= cnt_r + FIRST_CNT;
                    end
                end
                ST_SLEEP: begin
                    // oscillator stopped; only a write clearing sleep wakes it
                    if (!cmd_r.sleep) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    cnt_r   <= IDLE_CNT;
                end
            endcase
        end
    end

    logic conv_end;

    assign conv_end = clk_en && state_r == ST_CONV && cnt_r == CONV_LAST_CNT;

    // pin shares the status flag
    // decoded from flops so pin and status bit never disagree
    assign eoc          = state_r != ST_CONV && cnt_r == IDLE_CNT;
    assign integrating  = state_r == ST_CONV && cnt_r >= INT_START_CNT && cnt_r < int_end;
    assign read_zero    = cmd_r.read_zero;
    assign sleep_active = state_r == ST_SLEEP;

    // ----------------------------------------
    // result registers and collision flag
    // ----------------------------------------
    logic [15:0] result_r;
    logic [2:0]  fraction_r;
    logic        clash_r;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            result_r   <= 16'h0000;
            fraction_r <= 3'h0;
        end else if (conv_end) begin
            result_r   <= result_in;
            fraction_r <= fraction_in;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            clash_r <= 1'b0;
        end else if (clk_en) begin
            if (conv_end && reading) begin
                clash_r <= 1'b1;
            end else if (rd_done && cmd_r.sel == SEL_STATUS) begin
                clash_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    logic [7:0] status_byte;
    logic [7:0] data_out_nxt;
    // the registered mux costs a cycle of read latency but never glitches the pins

    assign status_byte = {clash_r, eoc, integrating, sleep_active, 1'b0, fraction_r};

    always_comb begin
        case (cmd_r.sel)
            SEL_RES_LO:  data_out_nxt = result_r[7:0];
            SEL_RES_HI:  data_out_nxt = result_r[15:8];
            SEL_STATUS:  data_out_nxt = status_byte;
            default:     data_out_nxt = RESET_BYTE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_out <= RESET_BYTE;
            data_oe  <= 1'b0;
        end else if (clk_en) begin
            data_out <= data_out_nxt;
            // drive while chip select and read are both low, else release
            data_oe  <= reading;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    AST_OE_CS: assert property (data_oe |-> $past(!pins_r.cs_n && !pins_r.rd_n))
        else $error("bus driven without chip select and read");

    AST_WR_SEL: assert property (clk_en && wr_done |=>
        cmd_r.sel == {$past(pins_prev_r.data[1]), $past(pins_prev_r.data[2])})
        else $error("select field not taken from d1 and d2");

    AST_INVALID: assert property (clk_en && cmd_r.sel == SEL_INVALID
        |=> data_out == 8'h00)
        else $error("invalid select did not read zero");

    AST_START_ONE: assert property (clk_en && state_r == ST_IDLE && cmd_r.start
        |=> state_r == ST_CONV && cnt_r == FIRST_CNT && !eoc)
        else $error("start at zero did not load count one");

    AST_START_CLR: assert property (start_clr && !wr_start |=> !cmd_r.start)
        else $error("start bit not cleared at count five");

    AST_WRAP: assert property (conv_end |=> eoc ##0 cnt_r == IDLE_CNT)
        else $error("conversion did not end after 1820 counts");

    AST_SLEEP: assert property (clk_en && eoc && cmd_r.sleep && !cmd_r.start
        |=> sleep_active)
        else $error("sleep not entered at conversion end");

    AST_RESULT: assert property (conv_end |=> result_r == $past(result_in))
        else $error("result not loaded at conversion end");

    AST_CLASH: assert property (conv_end && reading |=> clash_r)
        else $error("collision not flagged");

    AST_START_HOLD: assert property (clk_en && state_r == ST_CONV && cmd_r.start
        && cnt_r > START_CLR_CNT |=> cmd_r.start)
        else $error("late start not kept pending");

    AST_IDLE_STAY: assert property (clk_en && state_r == ST_IDLE && !cmd_r.start
        && !cmd_r.sleep |=> state_r == ST_IDLE && cnt_r == IDLE_CNT)
        else $error("converter left idle without a start");

    AST_CLASH_CLR: assert property (clk_en && rd_done && cmd_r.sel == SEL_STATUS
        |=> !clash_r)
        else $error("collision not cleared by status read");

    AST_OE_REL: assert property (clk_en && !reading |=> !data_oe)
        else $error("bus not released after read");

    COV_CONV: cover property (conv_end);
    COV_PENDING: cover property (conv_end && cmd_r.start);
    COV_GAP: cover property (state_r == ST_CONV && !clk_en);
    COV_STATUS_RD: cover property (rd_done && cmd_r.sel == SEL_STATUS && clash_r);
    COV_SLEEP: cover property (sleep_active ##1 !sleep_active);

endmodule // adcp_host_port

// >>> adcp_host_model.sv
// host processor model on the converter's 8-bit parallel bus
// assumes the bench resolves the shared data lines from the device enable alone
`timescale 1ns/1ps

module adcp_host_model
    import adcp_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic [7:0] bus_data,
    input  wire logic       dev_oe,
    output adcp_pins_s      pins
);
    logic       drv;
    logic [7:0] wbyte;

    initial begin
        pins  = '{1'b1, 1'b1, 1'b1, 8'h00};
        drv   = 1'b0;
        wbyte = 8'h00;
    end

    // host drives the byte only while writing
    // a released line toggles every cycle, so it shows the last byte every other cycle
    always @(posedge ref_clk) begin
        #1;
        if (drv) begin
            pins.data = wbyte;
        end else begin
            pins.data = ~pins.data;
        end
    end

    // write strobe held 4 cycles, data held past its rise
    task automatic wr(input logic [7:0] b);
        @(posedge ref_clk);
        wbyte = b;
        drv   = 1'b1;
        #1 pins.cs_n = 1'b0;
        pins.wr_n = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1 pins.wr_n = 1'b1;
        repeat (3) @(posedge ref_clk);
        drv = 1'b0;
        #1 pins.cs_n = 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask

    // read strobe held, byte taken at the edge before release
    task automatic rd(input logic cs, input int hold, output logic [7:0] b, output logic oe);
        @(posedge ref_clk);
        #1 pins.cs_n = cs;
        pins.rd_n = 1'b0;
        repeat (hold) @(posedge ref_clk);
        b  = bus_data;
        oe = dev_oe;
        #1 pins.cs_n = 1'b1;
        pins.rd_n = 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask

endmodule // adcp_host_model

// >>> tb_adc_host_command_port.sv
// self-checking bench of the converter host command port
// assumes the analog core result is steady except where a test changes it
`timescale 1ns/1ps

module tb_adc_host_command_port
    import adcp_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        clk_en = 1'b1;
    logic [15:0] result_in = 16'h8a5c;
    logic [2:0]  fraction_in = 3'h5;
    adcp_pins_s  pins;
    logic [7:0]  data_out, bus_data, rb;
    logic        data_oe, eoc, integrating, read_zero, sleep_active, oe;
    int          failures, checks_done, cyc, low_c, hi_c, int_c;
    int          last_low, last_hi, last_int;
    logic [7:0]  cm [4] = '{8'h00, 8'h04, 8'h0b, 8'h06};
    logic [7:0]  ex [4] = '{8'h5c, 8'h8a, 8'h45, 8'h00};

    assign bus_data = data_oe ? data_out : pins.data;
    always #10 ref_clk = ~ref_clk;

    adcp_host_port dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .cs_n(pins.cs_n),
        .rd_n(pins.rd_n), .wr_n(pins.wr_n), .data_in(bus_data), .data_out(data_out),
        .data_oe(data_oe), .result_in(result_in), .fraction_in(fraction_in), .eoc(eoc),
        .integrating(integrating), .read_zero(read_zero), .sleep_active(sleep_active)
    );

    adcp_host_model host (
        .ref_clk(ref_clk), .bus_data(bus_data), .dev_oe(data_oe), .pins(pins)
    );

    // ----------------------------------------
    // phase length monitors and timeout
    // ----------------------------------------
    always @(posedge ref_clk) begin
        cyc++;
        if (eoc === 1'b0) begin
            low_c++;
            if (hi_c != 0) last_hi = hi_c;
            hi_c = 0;
        end else begin
            hi_c++;
            if (low_c != 0) last_low = low_c;
            low_c = 0;
        end
        if (integrating === 1'b1) int_c++;
        else begin
            if (int_c != 0) last_int = int_c;
            int_c = 0;
        end
        if (cyc == 20000) begin
            failures++;
            $display("Error timeout expected end of tests seen cycle %0d", cyc);
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wait_eoc();
        int n;
        n = 0;
        @(posedge ref_clk);
        while (eoc !== 1'b1 && n < 4000) begin
            @(posedge ref_clk);
            n++;
        end
        chk("eoc_wait", 16'h1, eoc);
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic stop_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        chk("eoc_reset", 16'h1, eoc);
        chk("oe_reset", 16'h0, data_oe);
        chk("sleep_reset", 16'h0, sleep_active);
        host.rd(1'b1, 6, rb, oe);
        chk("oe_no_cs", 16'h0, oe);
        host.wr(8'h90);
        chk("read_zero", 16'h1, read_zero);
        wait_eoc();
        chk("conv_len", 16'd1819, last_low);
        chk("int_len60", 16'd546, last_int);
        repeat (100) @(posedge ref_clk);
        chk("eoc_idle", 16'h1, eoc);
        // selects in order low, high, status with don't-care bits, invalid
        for (int i = 0; i < 4; i++) begin
            host.wr(cm[i]);
            host.rd(1'b0, 8, rb, oe);
            chk("sel_read", ex[i], rb);
            chk("sel_oe", 16'h1, oe);
            chk("oe_released", 16'h0, data_oe);
        end
        host.wr(8'hc0);
        #1 result_in = 16'h1234;
        repeat (20) @(posedge ref_clk);
        host.wr(8'hc0);
        // read held across the conversion end raises the clash flag
        host.rd(1'b0, 2000, rb, oe);
        chk("new_low", 16'h34, rb);
        chk("eoc_gap", 16'd1, last_hi);
        chk("int_len50", 16'd655, last_int);
        wait_eoc();
        repeat (100) @(posedge ref_clk);
        chk("start_clear", 16'h1, eoc);
        host.wr(8'h0a);
        host.rd(1'b0, 8, rb, oe);
        chk("clash_set", 16'hc5, rb);
        host.rd(1'b0, 8, rb, oe);
        chk("clash_clear", 16'h45, rb);
        host.wr(8'h22);
        chk("sleep_on", 16'h1, sleep_active);
        host.rd(1'b0, 8, rb, oe);
        chk("sleep_status", 16'h55, rb);
        host.wr(8'h00);
        chk("sleep_off", 16'h0, sleep_active);
        // after waking, a full cycle passes before the next start
        repeat (1900) @(posedge ref_clk);
        #1 result_in = 16'h7f01;
        fraction_in = 3'h2;
        host.wr(8'h80);
        chk("read_zero_off", 16'h0, read_zero);
        // a clock enable gap before integration stretches the cycle by its length
        repeat (20) @(posedge ref_clk);
        #1 clk_en = 1'b0;
        repeat (50) @(posedge ref_clk);
        #1 clk_en = 1'b1;
        wait_eoc();
        chk("conv_len_gap", 16'd1869, last_low);
        chk("int_len_gap", 16'd546, last_int);
        host.wr(8'h04);
        host.rd(1'b0, 8, rb, oe);
        chk("pos_high", 16'h7f, rb);
        host.wr(8'h0a);
        host.rd(1'b0, 8, rb, oe);
        chk("fraction", 16'h42, rb);
        stop_test();
    end

endmodule // tb_adc_host_command_port
